// *** hdl/cpsb_pkg.sv ***
// Constants, state type and register layout for the copper port status and
// bypass register bank. Assumes a single 10 MHz clock domain.
package cpsb_pkg;

   // ----------------------------------------
   // Management frame timing
   // ----------------------------------------
   localparam logic [5:0] CPSB_PRE_LEN = 6'h20;   // Ones needed before a start
   localparam logic [4:0] CPSB_HDR_LAST = 5'h0b;  // Last op/address bit index
   localparam logic [4:0] CPSB_RD_BITS = 5'h10;   // Data bits driven on a read
   localparam logic [4:0] CPSB_WR_LAST = 5'h11;   // Turnaround plus data, last index
   localparam logic [1:0] CPSB_OP_READ = 2'h2;
   localparam logic [1:0] CPSB_OP_WRITE = 2'h1;

   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [4:0] CPSB_ADDR_FE_STAT = 5'h10;
   localparam logic [4:0] CPSB_ADDR_GE_STAT = 5'h11;
   localparam logic [4:0] CPSB_ADDR_BYPASS = 5'h12;
   localparam logic [4:0] CPSB_ADDR_RX_ERR = 5'h13;
   localparam logic [4:0] CPSB_ADDR_FALSE_CAR = 5'h14;
   localparam logic [4:0] CPSB_ADDR_LINK_DROP = 5'h15;
   localparam logic [4:0] CPSB_ADDR_EXT = 5'h16;

   // ----------------------------------------
   // Bypass control layout
   // ----------------------------------------
   localparam int CPSB_TX_OFF_BIT = 15;
   localparam int CPSB_NIBBLE_BIT = 14;
   localparam int CPSB_SCRAM_BIT = 13;
   localparam int CPSB_DESCRAM_BIT = 12;
   localparam int CPSB_PCS_RX_BIT = 11;
   localparam int CPSB_PCS_TX_BIT = 10;
   localparam int CPSB_LFI_BIT = 9;
   localparam int CPSB_XOVER_OFF_BIT = 7;
   localparam int CPSB_PAIR_SWAP_BIT = 5;
   localparam int CPSB_POLARITY_BIT = 4;
   localparam int CPSB_PAR_DET_BIT = 3;
   localparam int CPSB_PULSE_BIT = 2;
   localparam int CPSB_NEXT_PAGE_BIT = 1;
   localparam logic [15:0] CPSB_BYP_WMASK = 16'hfebe;
   localparam logic [15:0] CPSB_BYP_STICKY = 16'h003a;
   localparam logic [15:0] CPSB_BYP_RST = 16'h0088;

   // ----------------------------------------
   // Extended control/status layout
   // ----------------------------------------
   localparam int CPSB_FORCE_BIT = 15;
   localparam int CPSB_SQUELCH_HI = 11;
   localparam int CPSB_SQUELCH_LO = 10;
   localparam int CPSB_KEEP_BIT = 9;
   localparam int CPSB_EOF_BIT = 8;
   localparam int CPSB_TEN_DROP_BIT = 7;
   localparam int CPSB_TEN_UP_BIT = 6;
   localparam int CPSB_BCAST_BIT = 5;
   localparam logic [15:0] CPSB_EXT_WMASK = 16'h8e20;
   localparam logic [15:0] CPSB_EXT_STICKY = 16'h8c20;
   localparam logic [15:0] CPSB_EXT_RST = 16'h0200;

   // ----------------------------------------
   // Status layout and counters
   // ----------------------------------------
   localparam int CPSB_LOCK_BIT = 15;
   localparam int CPSB_LINK_BIT = 12;
   localparam int CPSB_LEGACY_BIT = 6;
   localparam int CPSB_XOVER_BIT = 5;
   localparam logic [7:0] CPSB_CNT_MAX = 8'hff;

   // Management frame states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_HDR = 3'b010,
      ST_TA = 3'b011,
      ST_RD = 3'b100,
      ST_WR = 3'b101
   } cpsb_state_e;

   // Whole state of the bank
   typedef struct packed {
      cpsb_state_e st;
      logic [5:0] pre_cnt;
      logic [4:0] bit_cnt;
      logic [15:0] shreg;
      logic [4:0] regad;
      logic wr_hit;
      logic [15:0] rdata;
      logic mdc_q;
      logic mdio_out;
      logic mdio_oe;
      logic [5:0] fe_lat;
      logic [6:0] ge_lat;
      logic eof_lat;
      logic ten_drop_lat;
      logic [15:0] byp;
      logic [15:0] ext;
      logic [7:0] rx_error_count;
      logic [7:0] fc_cnt;
      logic [7:0] drop_cnt;
   } cpsb_state_s;

   localparam cpsb_state_s CPSB_STATE_RST = '{
      st: ST_IDLE, pre_cnt: 6'h00, bit_cnt: 5'h00, shreg: 16'h0000, regad: 5'h00,
      wr_hit: 1'b0, rdata: 16'h0000, mdc_q: 1'b0, mdio_out: 1'b0, mdio_oe: 1'b0,
      fe_lat: 6'h00, ge_lat: 7'h00, eof_lat: 1'b0, ten_drop_lat: 1'b0,
      byp: CPSB_BYP_RST, ext: CPSB_EXT_RST, rx_error_count: 8'h00, fc_cnt: 8'h00,
      drop_cnt: 8'h00};

endpackage : cpsb_pkg

// *** hdl/cpsb_regs.sv ***
// Copper port status, bypass and extended control registers behind an
// MII management slave. Assumes mdc and mdio_in are synchronous to clk and
// that mdc is well below half the clk rate.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RQ1 - Fast status bit 15 shows live descrambler lock
// RQ2 - Fast error bits latch, clear on read
// RQ3 - Fast status bit 12 shows live link
// RQ4 - Fast fields valid only in 100 mode
// RQ5 - Gigabit bits 15, 12 show live lock, link
// RQ6 - Gigabit bits 14, 13 and 11 to 7 latch, read-clear
// RQ7 - Legacy partner bit valid only when locked
// RQ8 - Bit 5 shows crossover error condition
// RQ9 - Transmitter off powers down, zeros DAC
// RQ10 - Bits 14 to 9 bypass datapath elements
// RQ11 - Bit 7 disables forced-speed crossover, resets 1
// RQ12 - Bits 5, 4 disable swap, polarity fixes
// RQ13 - Bit 3 clear ignores own abilities
// RQ14 - Bit 2 disables pulse shaping filter
// RQ15 - Bit 1 stops automatic next pages
// RQ16 - Three saturating 8-bit counters, read-clear
// RQ17 - Bit 15 forces link pass, sticky
// RQ18 - Squelch select in 11:10, sticky, resets 0
// RQ19 - Bit 9 keeps sticky fields on soft reset
// RQ20 - Bit 8 latches defective end-of-frame
// RQ21 - Ten-meg drop flag latches; bit 6 live
// RQ22 - Broadcast bit accepts writes to any address
// RQ23 - Event during clearing read is kept
module cpsb_regs
   import cpsb_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic soft_rst,
   // Management pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] phy_addr,
   // Fast Ethernet status sources
   input wire logic fe_descrambler_lock,
   input wire logic fe_link_up,
   input wire logic fe_descrambler_fault,
   input wire logic fe_link_drop,
   input wire logic fe_rx_fault,
   input wire logic fe_tx_fault,
   input wire logic fe_stream_start_fault,
   input wire logic fe_stream_end_fault,
   // Gigabit status sources
   input wire logic ge_descrambler_lock,
   input wire logic ge_link_up,
   input wire logic ge_descrambler_fault,
   input wire logic ge_link_drop,
   input wire logic ge_rx_fault,
   input wire logic ge_tx_fault,
   input wire logic ge_stream_start_fault,
   input wire logic ge_stream_end_fault,
   input wire logic ge_carrier_ext_fault,
   input wire logic ge_legacy_partner_flag,
   input wire logic crossover_fault,
   // Counter events
   input wire logic rx_error_pkt,
   input wire logic false_carrier_evt,
   input wire logic link_drop_evt,
   // Ten-meg status sources
   input wire logic eof_fault_evt,
   input wire logic ten_link_drop_evt,
   input wire logic ten_link_up,
   // Datapath controls
   output logic transmitter_off,
   output logic nibble_code_bypass,
   output logic scrambler_bypass,
   output logic descrambler_bypass,
   output logic pcs_rx_bypass,
   output logic pcs_tx_bypass,
   output logic fail_inhibit_timer_bypass,
   output logic forced_speed_crossover_off,
   output logic pair_swap_fix_off,
   output logic polarity_fix_off,
   output logic parallel_detect_ability_check,
   output logic pulse_filter_off,
   output logic auto_next_page_off,
   // Extended controls
   output logic force_link_pass,
   output logic [1:0] squelch_level_sel,
   output logic keep_on_soft_reset,
   output logic write_to_all_ports
);

   // ----------------------------------------
   // State and helpers
   // ----------------------------------------
   cpsb_state_s q; // Registered state
   cpsb_state_s d; // Next state
   logic rise; // Management clock rising edge
   logic rd_take; // Read snapshot taken this cycle
   logic wr_take; // Accepted write this cycle
   logic [15:0] wr_word; // Data of accepted write
   logic [15:0] rd_val; // Value a read would return now
   logic [11:0] hdr; // Op, address and register bits
   logic [15:0] keep_mask; // Sticky fields kept on soft reset

   // Saturating count, clear first so a coincident event survives
   function automatic logic [7:0] sat_next(input logic [7:0] cnt, input logic evt,
                                           input logic clr);
      logic [7:0] base;
      base = clr ? 8'h00 : cnt;
      if (evt && base != CPSB_CNT_MAX)
      begin
         base = base + 8'h01;
      end
      return base;
   endfunction : sat_next

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      d = q;
      d.mdc_q = mdc;
      rise = mdc & ~q.mdc_q;
      rd_take = 1'b0;
      wr_take = 1'b0;
      wr_word = {q.shreg[14:0], mdio_in};
      hdr = {q.shreg[10:0], mdio_in};
      keep_mask = q.ext[CPSB_KEEP_BIT] ? 16'hffff : 16'h0000;

      // Read mux; speed-mode validity is left to software
      if (q.regad == CPSB_ADDR_FE_STAT)
      begin
         rd_val = {fe_descrambler_lock, q.fe_lat[5:4], fe_link_up, q.fe_lat[3:0], 8'h00}; // RQ1 RQ2 RQ3 RQ4
      end
      else if (q.regad == CPSB_ADDR_GE_STAT)
      begin
         rd_val = {ge_descrambler_lock, q.ge_lat[6:5], ge_link_up, q.ge_lat[4:0], // RQ5 RQ6
                   ge_legacy_partner_flag, crossover_fault, 5'h00}; // RQ7 RQ8
      end
      else if (q.regad == CPSB_ADDR_BYPASS)
      begin
         rd_val = q.byp;
      end
      else if (q.regad == CPSB_ADDR_RX_ERR)
      begin
         rd_val = {8'h00, q.rx_error_count};
      end
      else if (q.regad == CPSB_ADDR_FALSE_CAR)
      begin
         rd_val = {8'h00, q.fc_cnt};
      end
      else if (q.regad == CPSB_ADDR_LINK_DROP)
      begin
         rd_val = {8'h00, q.drop_cnt};
      end
      else if (q.regad == CPSB_ADDR_EXT)
      begin
         rd_val = q.ext;
         rd_val[CPSB_EOF_BIT] = q.eof_lat; // RQ20
         rd_val[CPSB_TEN_DROP_BIT] = q.ten_drop_lat; // RQ21
         rd_val[CPSB_TEN_UP_BIT] = ten_link_up; // RQ21
      end
      else
      begin
         // Unmapped addresses read as zero
         rd_val = 16'h0000;
      end

      // Frame decoder, advanced on each management clock rise
      if (rise)
      begin
         case (q.st)
            ST_IDLE:
            begin
               // Count preamble ones, a zero after enough of them starts a frame
               if (mdio_in)
               begin
                  if (q.pre_cnt != CPSB_PRE_LEN)
                  begin
                     d.pre_cnt = q.pre_cnt + 6'h01;
                  end
               end
               else
               begin
                  if (q.pre_cnt == CPSB_PRE_LEN)
                  begin
                     d.st = ST_START;
                  end
                  d.pre_cnt = 6'h00;
               end
            end
            ST_START:
            begin
               // Second start bit must be one
               d.st = mdio_in ? ST_HDR : ST_IDLE;
               d.bit_cnt = 5'h00;
            end
            ST_HDR:
            begin
               d.shreg = {q.shreg[14:0], mdio_in};
               d.bit_cnt = q.bit_cnt + 5'h01;
               if (q.bit_cnt == CPSB_HDR_LAST)
               begin
                  d.regad = hdr[4:0];
                  d.bit_cnt = 5'h00;
                  // Reads always decode the address; writes may be broadcast
                  d.wr_hit = (hdr[9:5] == phy_addr) || q.ext[CPSB_BCAST_BIT]; // RQ22
                  if (hdr[11:10] == CPSB_OP_READ && hdr[9:5] == phy_addr)
                  begin
                     d.st = ST_TA;
                  end
                  else if (hdr[11:10] == CPSB_OP_WRITE)
                  begin
                     d.st = ST_WR;
                  end
                  else
                  begin
                     d.st = ST_IDLE;
                  end
               end
            end
            ST_TA:
            begin
               // Drive the turnaround zero and freeze the read value
               d.mdio_oe = 1'b1;
               d.mdio_out = 1'b0;
               d.rdata = rd_val;
               rd_take = 1'b1;
               d.st = ST_RD;
            end
            ST_RD:
            begin
               if (q.bit_cnt == CPSB_RD_BITS)
               begin
                  d.mdio_oe = 1'b0;
                  d.st = ST_IDLE;
               end
               else
               begin
                  d.mdio_out = q.rdata[15];
                  d.rdata = {q.rdata[14:0], 1'b0};
                  d.bit_cnt = q.bit_cnt + 5'h01;
               end
            end
            ST_WR:
            begin
               // Turnaround bits fall off the top of the shifter
               d.shreg = {q.shreg[14:0], mdio_in};
               d.bit_cnt = q.bit_cnt + 5'h01;
               if (q.bit_cnt == CPSB_WR_LAST)
               begin
                  wr_take = q.wr_hit; // RQ22
                  d.st = ST_IDLE;
               end
            end
            default:
            begin
               d.st = ST_IDLE;
            end
         endcase
      end

      // Control writes, masked so read-only bits stay untouched
      if (wr_take && q.regad == CPSB_ADDR_BYPASS)
      begin
         d.byp = (q.byp & ~CPSB_BYP_WMASK) | (wr_word & CPSB_BYP_WMASK); // RQ10
      end
      if (wr_take && q.regad == CPSB_ADDR_EXT)
      begin
         d.ext = (q.ext & ~CPSB_EXT_WMASK) | (wr_word & CPSB_EXT_WMASK);
      end

      // Soft reset wins over a write; the keep bit itself always survives
      if (soft_rst)
      begin
         d.byp = (q.byp & CPSB_BYP_STICKY & keep_mask) | (CPSB_BYP_RST & ~(CPSB_BYP_STICKY & keep_mask)); // RQ19
         d.ext = (q.ext & CPSB_EXT_STICKY & keep_mask) | (CPSB_EXT_RST & ~CPSB_EXT_STICKY); // RQ19
         d.ext[CPSB_KEEP_BIT] = q.ext[CPSB_KEEP_BIT]; // RQ19
      end

      // Sticky flags: clear on read first, then set, so the set wins
      d.fe_lat = (rd_take && q.regad == CPSB_ADDR_FE_STAT) ? 6'h00 : q.fe_lat; // RQ2
      d.fe_lat = d.fe_lat | {fe_descrambler_fault, fe_link_drop, fe_rx_fault, fe_tx_fault,
                             fe_stream_start_fault, fe_stream_end_fault}; // RQ2 RQ23
      d.ge_lat = (rd_take && q.regad == CPSB_ADDR_GE_STAT) ? 7'h00 : q.ge_lat; // RQ6
      d.ge_lat = d.ge_lat | {ge_descrambler_fault, ge_link_drop, ge_rx_fault, ge_tx_fault,
                             ge_stream_start_fault, ge_stream_end_fault, ge_carrier_ext_fault}; // RQ6 RQ23
      d.eof_lat = ((rd_take && q.regad == CPSB_ADDR_EXT) ? 1'b0 : q.eof_lat) | eof_fault_evt; // RQ20 RQ23
      d.ten_drop_lat = ((rd_take && q.regad == CPSB_ADDR_EXT) ? 1'b0 : q.ten_drop_lat)
                       | ten_link_drop_evt; // RQ21 RQ23

      // Error counters
      d.rx_error_count = sat_next(q.rx_error_count, rx_error_pkt, rd_take && q.regad == CPSB_ADDR_RX_ERR); // RQ16
      d.fc_cnt = sat_next(q.fc_cnt, false_carrier_evt, rd_take && q.regad == CPSB_ADDR_FALSE_CAR); // RQ16
      d.drop_cnt = sat_next(q.drop_cnt, link_drop_evt, rd_take && q.regad == CPSB_ADDR_LINK_DROP); // RQ16
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q <= CPSB_STATE_RST;
      end
      else
      begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs, all straight from state bits
   // ----------------------------------------
   assign mdio_out = q.mdio_out;
   assign mdio_oe = q.mdio_oe;
   assign transmitter_off = q.byp[CPSB_TX_OFF_BIT]; // RQ9
   assign nibble_code_bypass = q.byp[CPSB_NIBBLE_BIT]; // RQ10
   assign scrambler_bypass = q.byp[CPSB_SCRAM_BIT]; // RQ10
   assign descrambler_bypass = q.byp[CPSB_DESCRAM_BIT]; // RQ10
   assign pcs_rx_bypass = q.byp[CPSB_PCS_RX_BIT]; // RQ10
   assign pcs_tx_bypass = q.byp[CPSB_PCS_TX_BIT]; // RQ10
   assign fail_inhibit_timer_bypass = q.byp[CPSB_LFI_BIT]; // RQ10
   assign forced_speed_crossover_off = q.byp[CPSB_XOVER_OFF_BIT]; // RQ11
   assign pair_swap_fix_off = q.byp[CPSB_PAIR_SWAP_BIT]; // RQ12
   assign polarity_fix_off = q.byp[CPSB_POLARITY_BIT]; // RQ12
   assign parallel_detect_ability_check = q.byp[CPSB_PAR_DET_BIT]; // RQ13
   assign pulse_filter_off = q.byp[CPSB_PULSE_BIT]; // RQ14
   assign auto_next_page_off = q.byp[CPSB_NEXT_PAGE_BIT]; // RQ15
   assign force_link_pass = q.ext[CPSB_FORCE_BIT]; // RQ17
   assign squelch_level_sel = q.ext[CPSB_SQUELCH_HI:CPSB_SQUELCH_LO]; // RQ18
   assign keep_on_soft_reset = q.ext[CPSB_KEEP_BIT];
   assign write_to_all_ports = q.ext[CPSB_BCAST_BIT];

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_ext_write;
      wr_take && q.regad == CPSB_ADDR_EXT && !soft_rst;
   endsequence

   sequence s_fe_read;
      rd_take && q.regad == CPSB_ADDR_FE_STAT;
   endsequence

   a_fe_lock_live: assert property (@(posedge clk) disable iff (rst) // RQ1
      s_fe_read |=> q.rdata[CPSB_LOCK_BIT] == $past(fe_descrambler_lock))
      else $error("fast lock bit not live");
   a_fe_err_latch: assert property (@(posedge clk) disable iff (rst) // RQ2
      fe_tx_fault || (q.fe_lat[2] && !(rd_take && q.regad == CPSB_ADDR_FE_STAT)) |=> q.fe_lat[2])
      else $error("fast error flag lost");
   a_fe_link_live: assert property (@(posedge clk) disable iff (rst) // RQ3
      s_fe_read |=> q.rdata[CPSB_LINK_BIT] == $past(fe_link_up))
      else $error("fast link bit not live");
   a_ge_live_bits: assert property (@(posedge clk) disable iff (rst) // RQ5
      rd_take && q.regad == CPSB_ADDR_GE_STAT |=>
      q.rdata[CPSB_LOCK_BIT] == $past(ge_descrambler_lock) && q.rdata[CPSB_LINK_BIT] == $past(ge_link_up))
      else $error("gigabit live bits wrong");
   a_ge_read_clear: assert property (@(posedge clk) disable iff (rst) // RQ6
      rd_take && q.regad == CPSB_ADDR_GE_STAT && !ge_carrier_ext_fault |=> !q.ge_lat[0])
      else $error("gigabit flag not cleared by read");
   a_count_saturate: assert property (@(posedge clk) disable iff (rst) // RQ16
      q.fc_cnt == CPSB_CNT_MAX && !rd_take |=> q.fc_cnt == CPSB_CNT_MAX)
      else $error("counter wrapped");
   a_soft_keep: assert property (@(posedge clk) disable iff (rst) // RQ19
      soft_rst |=> keep_on_soft_reset == $past(keep_on_soft_reset)
      && ($past(keep_on_soft_reset) || squelch_level_sel == 2'h0))
      else $error("soft reset handling wrong");
   a_bcast_write: assert property (@(posedge clk) disable iff (rst) // RQ22
      s_ext_write |=> force_link_pass == $past(wr_word[CPSB_FORCE_BIT]))
      else $error("accepted write not stored");
   a_set_wins: assert property (@(posedge clk) disable iff (rst) // RQ23
      rd_take && q.regad == CPSB_ADDR_EXT && eof_fault_evt |=> q.eof_lat)
      else $error("event lost during clearing read");
   a_tx_off_write: assert property (@(posedge clk) disable iff (rst) // RQ9
      wr_take && q.regad == CPSB_ADDR_BYPASS && !soft_rst |=> transmitter_off == $past(wr_word[CPSB_TX_OFF_BIT]))
      else $error("transmitter off not written");

endmodule : cpsb_regs

`default_nettype wire

// *** verif/cpsb_host.sv ***
// Management host model: sends read and write frames on mdc/mdio.
// Assumes clk comes from the bench; pins change on its falling edge.
`timescale 1ns/100ps
`default_nettype none
module cpsb_host
   import cpsb_pkg::*;
(
   // Clock
   input wire logic clk,
   // Management pins
   output logic mdc,
   output logic mdio_in,
   input wire logic mdio_out,
   input wire logic mdio_oe
);
   // ----------------------------------------
   // Wire level
   // ----------------------------------------
   logic host_d = 1'b1; // Host data bit
   logic host_en = 1'b0; // Host drives the line
   initial mdc = 1'b0;
   // Device wins while it drives; released line floats to the pull-up
   assign mdio_in = mdio_oe ? mdio_out : (host_en ? host_d : 1'b1);

   // ----------------------------------------
   // One mdc period, 2 clk low and 2 clk high
   // ----------------------------------------
   task automatic bit_cycle(input logic b, input logic en);
      host_d = b;
      host_en = en;
      mdc = 1'b0;
      repeat (2) @(negedge clk);
      mdc = 1'b1;
      // Return in the high phase, after the answer has settled
      repeat (2) @(negedge clk);
   endtask : bit_cycle

   // ----------------------------------------
   // Whole frame with a fresh preamble
   // ----------------------------------------
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd, output logic oe_ok);
      logic [13:0] hdr;
      logic [17:0] tail;
      hdr = {2'b01, op, pa, ra};
      tail = {2'b10, wd};
      oe_ok = 1'b1;
      rd = 16'h0000;
      repeat (32) bit_cycle(1'b1, 1'b1);
      for (int i = 13; i >= 0; i--) bit_cycle(hdr[i], 1'b1);
      for (int j = 0; j < 18; j++)
      begin
         bit_cycle(tail[17 - j], op == CPSB_OP_WRITE);
         // Bits taken as shown; speed-mode validity is the caller's concern
         if (j >= 1 && j <= 16)
         begin
            rd[16 - j] = mdio_in;
            oe_ok &= mdio_oe;
         end
      end
      host_en = 1'b0;
   endtask : frame
endmodule : cpsb_host
`default_nettype wire

// *** verif/copper_phy_status_bypass_regs_bench.sv ***
// Self-checking bench for the register bank, one task per scenario.
// Assumes cpsb_pkg and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module copper_phy_status_bypass_regs_bench
   import cpsb_pkg::*;
;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic soft_rst = 1'b0;
   logic [24:0] src = '0; // Status levels and event sources
   logic mdc, mdio_in, mdio_out, mdio_oe;
   logic [12:0] byp_o; // Datapath control outputs
   logic [1:0] sq_o;
   logic force_o, keep_o, bcast_o;
   logic [15:0] rd;
   logic ok;
   int fails = 0;
   int checks = 0;
   int cycles = 0;

   always #50 clk = ~clk;

   cpsb_host host (.clk(clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

   cpsb_regs dut (.clk(clk), .rst(rst), .soft_rst(soft_rst), .mdc(mdc), .mdio_in(mdio_in),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(5'h03),
      .fe_descrambler_lock(src[0]), .fe_link_up(src[1]), .fe_descrambler_fault(src[2]),
      .fe_link_drop(src[3]), .fe_rx_fault(src[4]), .fe_tx_fault(src[5]),
      .fe_stream_start_fault(src[6]), .fe_stream_end_fault(src[7]),
      .ge_descrambler_lock(src[8]), .ge_link_up(src[9]), .ge_descrambler_fault(src[10]),
      .ge_link_drop(src[11]), .ge_rx_fault(src[12]), .ge_tx_fault(src[13]),
      .ge_stream_start_fault(src[14]), .ge_stream_end_fault(src[15]),
      .ge_carrier_ext_fault(src[16]), .ge_legacy_partner_flag(src[17]), .crossover_fault(src[18]),
      .rx_error_pkt(src[19]), .false_carrier_evt(src[20]), .link_drop_evt(src[21]),
      .eof_fault_evt(src[22]), .ten_link_drop_evt(src[23]), .ten_link_up(src[24]),
      .transmitter_off(byp_o[12]), .nibble_code_bypass(byp_o[11]), .scrambler_bypass(byp_o[10]),
      .descrambler_bypass(byp_o[9]), .pcs_rx_bypass(byp_o[8]), .pcs_tx_bypass(byp_o[7]),
      .fail_inhibit_timer_bypass(byp_o[6]), .forced_speed_crossover_off(byp_o[5]),
      .pair_swap_fix_off(byp_o[4]), .polarity_fix_off(byp_o[3]),
      .parallel_detect_ability_check(byp_o[2]), .pulse_filter_off(byp_o[1]),
      .auto_next_page_off(byp_o[0]), .force_link_pass(force_o), .squelch_level_sel(sq_o),
      .keep_on_soft_reset(keep_o), .write_to_all_ports(bcast_o));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd_reg(input logic [4:0] ra, input logic [4:0] pa = 5'h03);
      host.frame(CPSB_OP_READ, pa, ra, 16'h0000, rd, ok);
   endtask : rd_reg

   task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd, input logic [4:0] pa = 5'h03);
      logic [15:0] unused_rd;
      logic unused_ok;
      host.frame(CPSB_OP_WRITE, pa, ra, wd, unused_rd, unused_ok);
   endtask : wr_reg

   // Events high for n cycles between frames
   task automatic pulse(input logic [24:0] m, input int n);
      @(negedge clk);
      src ^= m;
      repeat (n) @(negedge clk);
      src ^= m;
   endtask : pulse

   // Soft reset as a one-cycle request
   task automatic soft_pulse();
      @(negedge clk);
      soft_rst = 1'b1;
      @(negedge clk);
      soft_rst = 1'b0;
   endtask : soft_pulse

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd_reg(CPSB_ADDR_BYPASS);
      check("bypass reset", rd, 16'h0088);
      check("read drive", {15'h0, ok}, 16'h0001);
      check("bypass pins", {3'h0, byp_o}, 16'h0024);
      rd_reg(CPSB_ADDR_EXT);
      check("ext reset", rd, 16'h0200);
   endtask : t_reset

   task automatic t_status();
      src[1:0] = 2'b11;
      src[9:8] = 2'b11;
      src[18:17] = 2'b11;
      pulse(25'h01fcfc, 1);
      rd_reg(CPSB_ADDR_FE_STAT);
      check("fast flags", rd, 16'hff00);
      rd_reg(CPSB_ADDR_GE_STAT);
      check("gig flags", rd, 16'hffe0);
      src[0] = 1'b0;
      src[8] = 1'b0;
      src[18] = 1'b0;
      rd_reg(CPSB_ADDR_FE_STAT);
      check("fast cleared", rd, 16'h1000);
      rd_reg(CPSB_ADDR_GE_STAT);
      check("gig cleared", rd, 16'h1040);
   endtask : t_status

   // Counting past the ceiling shows saturation
   task automatic t_count();
      pulse(25'h080000, 3);
      pulse(25'h100000, 260);
      pulse(25'h200000, 1);
      rd_reg(CPSB_ADDR_RX_ERR);
      check("rx count", rd, 16'h0003);
      rd_reg(CPSB_ADDR_FALSE_CAR);
      check("carrier count", rd, 16'h00ff);
      rd_reg(CPSB_ADDR_LINK_DROP);
      check("drop count", rd, 16'h0001);
      rd_reg(CPSB_ADDR_FALSE_CAR);
      check("count cleared", rd, 16'h0000);
   endtask : t_count

   task automatic t_sticky();
      wr_reg(CPSB_ADDR_BYPASS, 16'hfeb6);
      rd_reg(CPSB_ADDR_BYPASS);
      check("bypass rw", rd, 16'hfeb6);
      check("bypass pins", {3'h0, byp_o}, 16'h1ffb);
      wr_reg(CPSB_ADDR_EXT, 16'h8e20);
      check("ext pins", {11'h0, force_o, sq_o, keep_o, bcast_o}, 16'h001f);
      soft_pulse();
      rd_reg(CPSB_ADDR_BYPASS);
      check("bypass kept", rd, 16'h00b2);
      rd_reg(CPSB_ADDR_EXT);
      check("ext kept", rd, 16'h8e20);
      wr_reg(CPSB_ADDR_EXT, 16'h0c00);
      soft_pulse();
      rd_reg(CPSB_ADDR_BYPASS);
      check("bypass default", rd, 16'h0088);
      rd_reg(CPSB_ADDR_EXT);
      check("ext default", rd, 16'h0000);
   endtask : t_sticky

   task automatic t_bcast();
      wr_reg(CPSB_ADDR_EXT, 16'h0220);
      wr_reg(CPSB_ADDR_BYPASS, 16'h0400, 5'h1c);
      rd_reg(CPSB_ADDR_BYPASS);
      check("any-address write", rd, 16'h0400);
      rd_reg(CPSB_ADDR_BYPASS, 5'h1c);
      check("foreign read", {rd[15:1], ok}, 16'hfffe);
      wr_reg(CPSB_ADDR_EXT, 16'h0200);
      wr_reg(CPSB_ADDR_BYPASS, 16'h0800, 5'h1c);
      rd_reg(CPSB_ADDR_BYPASS);
      check("foreign write", rd, 16'h0400);
   endtask : t_bcast

   task automatic t_ten();
      src[24:22] = 3'b101;
      pulse(25'h800000, 1);
      rd_reg(CPSB_ADDR_EXT);
      check("ten flags", rd, 16'h03c0);
      src[24:22] = 3'b000;
      rd_reg(CPSB_ADDR_EXT);
      check("ten cleared", rd, 16'h0300);
   endtask : t_ten

   // ----------------------------------------
   // Verdict, hang guard and main sequence
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_status();
      t_count();
      t_sticky();
      t_bcast();
      t_ten();
      tally_and_finish();
   end
endmodule : copper_phy_status_bypass_regs_bench
`default_nettype wire
